// ===== inc/pbs_params.svh
// Constants for the pipelined burst SRAM control block.
`ifndef PBS_PARAMS_SVH
`define PBS_PARAMS_SVH

// ============================================================
// Widths
`define PBS_ADDR_W      18
`define PBS_DATA_W      18
`define PBS_LANE_W      9
`define PBS_LANES       2
`define PBS_CNT_W       2
`define PBS_FIFO_DEPTH  8

// ============================================================
// Field positions and values
`define PBS_LANE_LO     0
`define PBS_LANE_HI     1
`define PBS_CNT_ZERO    2'h0
`define PBS_CNT_STEP    2'h1
`define PBS_LANES_ALL   2'h3
`define PBS_LANES_NONE  2'h0

`endif

// ===== inc/pbs_pkg.sv
// Types shared by the burst SRAM control block.
`include "pbs_params.svh"

package pbs_pkg;

    // ============================================================
    // Burst state and decoded cycle kind
    typedef enum logic [1:0] {
        PBS_ST_IDLE,
        PBS_ST_READ,
        PBS_ST_WRITE
    } pbs_state_t;

    typedef enum logic [2:0] {
        PBS_CYC_DESEL,
        PBS_CYC_BEGIN_RD,
        PBS_CYC_BEGIN_WR,
        PBS_CYC_CONT,
        PBS_CYC_SUSP
    } pbs_cycle_t;

    // ============================================================
    // One queued write towards the array
    typedef struct packed {
        logic [`PBS_ADDR_W-1:0] addr;
        logic [`PBS_LANES-1:0]  lanes;
        logic [`PBS_DATA_W-1:0] data;
    } pbs_wr_t;

endpackage

// ===== rtl/pbs_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/100ps
`default_nettype none

module pbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [CW-1:0] CNT_ONE  = CW'(1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wptr, next_wptr, rptr, next_rptr;
    logic [CW-1:0]    count, next_count;
    logic             not_full, next_not_full;
    logic             not_empty, next_not_empty;
    logic             push, pop;

    assign in_ready  = not_full;
    assign out_valid = not_empty;
    assign out_data  = mem[rptr];
    assign push      = in_valid & not_full;
    assign pop       = out_ready & not_empty;

    // ============================================================
    // Pointer and level update; flags kept as flops for clean ports
    always_comb begin
        next_wptr  = wptr;
        next_rptr  = rptr;
        next_count = count;
        if (push) begin
            next_wptr = (wptr == PTR_LAST) ? '0 : wptr + PW'(1);
        end
        if (pop) begin
            next_rptr = (rptr == PTR_LAST) ? '0 : rptr + PW'(1);
        end
        if (push && !pop) begin
            next_count = count + CNT_ONE;
        end else if (pop && !push) begin
            next_count = count - CNT_ONE;
        end
        next_not_full  = (next_count != CNT_FULL);
        next_not_empty = (next_count != '0);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wptr      <= '0;
            rptr      <= '0;
            count     <= '0;
            not_full  <= 1'b1;
            not_empty <= 1'b0;
        end else begin
            wptr      <= next_wptr;
            rptr      <= next_rptr;
            count     <= next_count;
            not_full  <= next_not_full;
            not_empty <= next_not_empty;
        end
    end

    // Storage needs no reset; only written entries are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr] <= in_data;
        end
    end

endmodule

`default_nettype wire

// ===== rtl/pbs_ctrl.sv
// Control logic of a pipelined burst SRAM: cycle decode and burst counter.
`timescale 1ns/100ps
`default_nettype none
`include "pbs_params.svh"

module pbs_ctrl import pbs_pkg::*; (
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire logic [`PBS_ADDR_W-1:0] addr_in,
    input  wire logic                   proc_burst_start_n,
    input  wire logic                   ctrl_burst_start_n,
    input  wire logic                   burst_advance_n,
    input  wire logic                   chip_enable_primary_n,
    input  wire logic                   chip_enable_depth_hi,
    input  wire logic                   chip_enable_depth_lo_n,
    input  wire logic                   global_write_n,
    input  wire logic                   write_strobe_n,
    input  wire logic                   byte_write_lane_lo_n,
    input  wire logic                   byte_write_lane_hi_n,
    input  wire logic                   output_enable_n,
    input  wire logic                   burst_order_select,
    input  wire logic [`PBS_DATA_W-1:0] data_in,
    output logic      [`PBS_DATA_W-1:0] data_out,
    output logic                        data_oe_n,
    output logic      [`PBS_ADDR_W-1:0] mem_rd_addr,
    output logic                        mem_rd,
    input  wire logic [`PBS_DATA_W-1:0] mem_rdata,
    output pbs_wr_t                     mem_wr,
    output logic                        mem_wr_valid,
    input  wire logic                   mem_wr_ready,
    output logic                        wr_ready,
    output logic                        wr_overflow
);

    // ============================================================
    // Registers and decode wires
    pbs_state_t             state, next_state;
    logic [`PBS_ADDR_W-1:0] base, next_base;
    logic [`PBS_CNT_W-1:0]  cnt, next_cnt;
    logic [`PBS_ADDR_W-1:0] next_rd_addr;
    logic                   next_mem_rd;
    logic [`PBS_DATA_W-1:0] next_data_out;
    logic                   rd_valid, next_rd_valid;
    logic                   next_overflow;

    pbs_cycle_t             cycle;
    logic                   proc_start, ctrl_start;
    logic                   depth_ok, all_enabled;
    logic                   is_write;
    logic [`PBS_LANES-1:0]  lanes;
    logic [`PBS_CNT_W-1:0]  cyc_cnt;
    logic [`PBS_ADDR_W-1:0] cyc_addr;
    logic [`PBS_CNT_W-1:0]  cur_lsb;
    logic                   push;
    pbs_wr_t                push_entry;
    logic                   fifo_in_ready;

    // ============================================================
    // Burst order: the low two bits of the start address seed the
    // sequence; the order pin is used live, it is never captured
    function automatic logic [`PBS_CNT_W-1:0] burst_lsb(
        input logic [`PBS_CNT_W-1:0] start,
        input logic [`PBS_CNT_W-1:0] step,
        input logic                  interleave
    );
        logic [`PBS_CNT_W-1:0] r;
        if (interleave) begin
            r = start ^ step;
        end else begin
            r = start + step;
        end
        return r;
    endfunction

    // Upper bits stay as latched for the whole four-beat burst
    assign cur_lsb = burst_lsb(base[`PBS_CNT_W-1:0], cnt,
                               burst_order_select);

    // ============================================================
    // Write strobes: global write overrides byte lanes
    always_comb begin
        if (!global_write_n) begin
            lanes = `PBS_LANES_ALL;
        end else if (!write_strobe_n) begin
            lanes = {~byte_write_lane_hi_n,
                     ~byte_write_lane_lo_n};
        end else begin
            lanes = `PBS_LANES_NONE;
        end
        is_write = (lanes != `PBS_LANES_NONE);
    end

    // ============================================================
    // Next-cycle decode; a controller start with any enable off deselects, a processor start only with a depth enable off
    assign proc_start  = !proc_burst_start_n;
    assign ctrl_start  = !ctrl_burst_start_n;
    assign depth_ok    = chip_enable_depth_hi && !chip_enable_depth_lo_n;
    assign all_enabled = !chip_enable_primary_n && depth_ok;

    always_comb begin
        if (proc_start && !chip_enable_primary_n) begin
            // Primary enable high makes the processor start invisible
            if (depth_ok) begin
                cycle = PBS_CYC_BEGIN_RD;
            end else begin
                cycle = PBS_CYC_DESEL;
            end
        end else if (ctrl_start) begin
            if (!all_enabled) begin
                cycle = PBS_CYC_DESEL;
            end else if (is_write) begin
                cycle = PBS_CYC_BEGIN_WR;
            end else begin
                cycle = PBS_CYC_BEGIN_RD;
            end
        end else if (!burst_advance_n) begin
            cycle = PBS_CYC_CONT;
        end else begin
            cycle = PBS_CYC_SUSP;
        end
    end

    // ============================================================
    // Burst state, counter and address for this cycle
    always_comb begin
        next_state = state;
        next_base  = base;
        next_cnt   = cnt;
        cyc_cnt    = cnt;
        cyc_addr   = {base[`PBS_ADDR_W-1:`PBS_CNT_W], cur_lsb};
        case (cycle)
            PBS_CYC_DESEL: begin
                next_state = PBS_ST_IDLE;
            end
            PBS_CYC_BEGIN_RD: begin
                // A new start aborts whatever burst was running
                next_state = PBS_ST_READ;
                next_base  = addr_in;
                next_cnt   = `PBS_CNT_ZERO;
                cyc_addr   = addr_in;
            end
            PBS_CYC_BEGIN_WR: begin
                next_state = PBS_ST_WRITE;
                next_base  = addr_in;
                next_cnt   = `PBS_CNT_ZERO;
                cyc_addr   = addr_in;
            end
            PBS_CYC_CONT: begin
                if (state != PBS_ST_IDLE) begin
                    cyc_cnt  = cnt + `PBS_CNT_STEP;
                    next_cnt = cyc_cnt;
                    cyc_addr = {base[`PBS_ADDR_W-1:`PBS_CNT_W],
                                burst_lsb(base[`PBS_CNT_W-1:0], cyc_cnt,
                                          burst_order_select)};
                end
            end
            PBS_CYC_SUSP: begin
                next_cnt = cnt;
            end
            default: begin
                next_state = PBS_ST_IDLE;
            end
        endcase
    end

    // ============================================================
    // Array side: read address is registered, write goes through FIFO
    always_comb begin
        push = (cycle == PBS_CYC_BEGIN_WR)
            || (state == PBS_ST_WRITE
                && (cycle == PBS_CYC_CONT || cycle == PBS_CYC_SUSP)
                && is_write);
        push_entry.addr  = cyc_addr;
        push_entry.lanes = lanes;
        push_entry.data  = data_in;
        next_mem_rd   = (next_state == PBS_ST_READ);
        next_rd_addr  = next_mem_rd ? cyc_addr : mem_rd_addr;
        // Read data of the previous cycle lands in the output register
        next_rd_valid = mem_rd;
        next_data_out = mem_rd ? mem_rdata : data_out;
        // The pins cannot be held off, so a lost write is only flagged
        next_overflow = wr_overflow || (push && !fifo_in_ready);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state       <= PBS_ST_IDLE;
            base        <= '0;
            cnt         <= `PBS_CNT_ZERO;
            mem_rd      <= 1'b0;
            mem_rd_addr <= '0;
            rd_valid    <= 1'b0;
            data_out    <= '0;
            wr_overflow <= 1'b0;
        end else begin
            state       <= next_state;
            base        <= next_base;
            cnt         <= next_cnt;
            mem_rd      <= next_mem_rd;
            mem_rd_addr <= next_rd_addr;
            rd_valid    <= next_rd_valid;
            data_out    <= next_data_out;
            wr_overflow <= next_overflow;
        end
    end

    // Output enable bypasses the clock so the bus turns on at once;
    // write cycles never load read data so the pins stay off from the second write cycle on
    assign data_oe_n = !(rd_valid && !output_enable_n);

    // ============================================================
    // Write queue towards the array
    pbs_fifo #(
        .WIDTH ($bits(pbs_wr_t)),
        .DEPTH (`PBS_FIFO_DEPTH)
    ) u_wr_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .in_data   (push_entry),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .out_data  (mem_wr),
        .out_valid (mem_wr_valid),
        .out_ready (mem_wr_ready)
    );

    assign wr_ready = fifo_in_ready;

    // ============================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    global_lanes_a: assert property (
        (push && !global_write_n) |-> push_entry.lanes == `PBS_LANES_ALL)
        else $error("global write did not select all lanes");

    strobe_lanes_a: assert property (
        (push && global_write_n)
        |-> push_entry.lanes == {~byte_write_lane_hi_n,
                                 ~byte_write_lane_lo_n})
        else $error("byte lanes do not follow byte strobes");

    primary_block_a: assert property (
        (proc_start && chip_enable_primary_n && !ctrl_start
         && burst_advance_n) |=> $stable(state) && $stable(base))
        else $error("processor start taken with primary enable high");

    depth_desel_a: assert property (
        ((proc_start || ctrl_start) && !depth_ok
         && !(proc_start && chip_enable_primary_n))
        |=> state == PBS_ST_IDLE ##1 !rd_valid)
        else $error("depth enable did not deselect");

    proc_read_a: assert property (
        (proc_start && all_enabled)
        |=> state == PBS_ST_READ && base == $past(addr_in)
            && mem_rd_addr == $past(addr_in) && data_oe_n)
        else $error("processor start did not begin a read");

    ctrl_begin_a: assert property (
        (!proc_start && ctrl_start && all_enabled)
        |=> base == $past(addr_in) && cnt == `PBS_CNT_ZERO
            && state == ($past(is_write) ? PBS_ST_WRITE : PBS_ST_READ))
        else $error("controller start did not latch address");

    advance_step_a: assert property (
        (cycle == PBS_CYC_CONT && state != PBS_ST_IDLE)
        |=> cnt == $past(cnt) + `PBS_CNT_STEP && $stable(base))
        else $error("advance did not step the counter");

    suspend_hold_a: assert property (
        (cycle == PBS_CYC_SUSP) |=> $stable(cnt) && $stable(base)
            && $stable(mem_rd_addr))
        else $error("suspend changed the burst address");

    read_latency_a: assert property (
        mem_rd |=> rd_valid && data_out == $past(mem_rdata))
        else $error("read data not registered one cycle later");

    write_hiz_a: assert property (
        (state == PBS_ST_WRITE && $past(state) == PBS_ST_WRITE)
        |-> data_oe_n)
        else $error("data pins driven during write burst");

    oe_async_a: assert property (
        (rd_valid && !output_enable_n) |-> !data_oe_n)
        else $error("output enable did not drive the pins");

    linear_seq_a: assert property (
        !burst_order_select
        |-> cur_lsb == base[`PBS_CNT_W-1:0] + cnt)
        else $error("linear burst order wrong");

    interleave_seq_a: assert property (
        burst_order_select
        |-> cur_lsb == (base[`PBS_CNT_W-1:0] ^ cnt))
        else $error("interleaved burst order wrong");

    upper_hold_a: assert property (
        (cycle == PBS_CYC_CONT || cycle == PBS_CYC_SUSP)
        |=> $stable(base[`PBS_ADDR_W-1:`PBS_CNT_W]))
        else $error("upper address bits moved during burst");

endmodule

`default_nettype wire

// ===== verif/pbs_array_model.sv
// Behavioural storage array on the far side of the burst SRAM control.
`timescale 1ns/100ps
`default_nettype none
`include "pbs_params.svh"

module pbs_array_model import pbs_pkg::*; (
    input  wire logic                   clk,
    input  wire logic [`PBS_ADDR_W-1:0] mem_rd_addr,
    input  wire logic                   mem_rd,
    output logic      [`PBS_DATA_W-1:0] mem_rdata,
    input  wire pbs_wr_t                mem_wr,
    input  wire logic                   mem_wr_valid,
    output logic                        mem_wr_ready,
    input  wire logic                   stall
);
    logic [`PBS_DATA_W-1:0] store [logic [`PBS_ADDR_W-1:0]];
    logic [`PBS_DATA_W-1:0] last;
    logic [`PBS_DATA_W-1:0] word;

    // ============================================================
    // Read side
    // Unwritten words read as an address pattern so no two beats match
    function automatic logic [`PBS_DATA_W-1:0] look(
        input logic [`PBS_ADDR_W-1:0] a);
        return store.exists(a) ? store[a] : a ^ 18'h2_aaaa;
    endfunction

    // Outside a read the bus shows the inverse of its last value
    assign mem_rdata = mem_rd ? look(mem_rd_addr) : ~last;
    always @(posedge clk) begin
        last <= mem_rdata;
    end

    // ============================================================
    // Write side: a stall holds every queued write back
    assign mem_wr_ready = !stall;
    always @(posedge clk) begin
        if (mem_wr_valid && mem_wr_ready) begin
            word = look(mem_wr.addr);
            if (mem_wr.lanes[`PBS_LANE_LO])
                word[8:0] = mem_wr.data[8:0];
            if (mem_wr.lanes[`PBS_LANE_HI])
                word[17:9] = mem_wr.data[17:9];
            store[mem_wr.addr] = word;
        end
    end
endmodule
`default_nettype wire

// ===== verif/tb_pipelined_burst_sram_control.sv
// Self-checking testbench of the pipelined burst SRAM control block.
`timescale 1ns/100ps
`default_nettype none
`include "pbs_params.svh"

module tb_pipelined_burst_sram_control;
    // Strobe sets {proc start, ctrl start, advance}, all active low
    localparam logic [2:0] PS = 3'h3, CS = 3'h5, BURST_ADVANCE_N = 3'h6, HOLD = 3'h7;
    localparam logic [2:0] PSADV = 3'h2;
    // Enable sets {primary_n, depth_hi, depth_lo_n}
    localparam logic [2:0] ON = 3'h2, PRI_OFF = 3'h6;
    localparam logic [2:0] HI_OFF = 3'h0, LO_OFF = 3'h3;
    // Write sets {global_n, strobe_n, lane_hi_n, lane_lo_n}
    localparam logic [3:0] NOWR = 4'hf, GW = 4'h7, LLO = 4'ha, LHI = 4'h9;
    localparam logic [3:0] BOTH = 4'h8, NOLANE = 4'hb, SWOFF = 4'hc;
    localparam int LIMIT = 3000;

    logic        clk = 1'b0, resetn = 1'b0, stall = 1'b0;
    logic [17:0] addr_in = 18'h0_0000, data_in = 18'h0_0000;
    logic        proc_burst_start_n = 1'b1, ctrl_burst_start_n = 1'b1;
    logic        burst_advance_n = 1'b1, chip_enable_primary_n = 1'b0;
    logic        chip_enable_depth_hi = 1'b1, chip_enable_depth_lo_n = 1'b0;
    logic        global_write_n = 1'b1, write_strobe_n = 1'b1;
    logic        byte_write_lane_lo_n = 1'b1, byte_write_lane_hi_n = 1'b1;
    logic        output_enable_n = 1'b1, burst_order_select = 1'b0;
    logic        oe_sel = 1'b1, order_sel = 1'b0;
    logic [17:0] data_out, mem_rd_addr, mem_rdata;
    logic        data_oe_n, mem_rd, mem_wr_valid, mem_wr_ready;
    logic        wr_ready, wr_overflow;
    pbs_pkg::pbs_wr_t mem_wr;
    int          n_fail = 0, checks_done = 0, cycles = 0;

    pbs_ctrl u_pbs_ctrl (.clk, .resetn, .addr_in, .proc_burst_start_n,
        .ctrl_burst_start_n, .burst_advance_n, .chip_enable_primary_n,
        .chip_enable_depth_hi, .chip_enable_depth_lo_n, .global_write_n,
        .write_strobe_n, .byte_write_lane_lo_n, .byte_write_lane_hi_n,
        .output_enable_n, .burst_order_select, .data_in, .data_out,
        .data_oe_n, .mem_rd_addr, .mem_rd, .mem_rdata, .mem_wr,
        .mem_wr_valid, .mem_wr_ready, .wr_ready, .wr_overflow);
    pbs_array_model u_pbs_array_model (.clk, .mem_rd_addr, .mem_rd,
        .mem_rdata, .mem_wr, .mem_wr_valid, .mem_wr_ready, .stall);

    // ============================================================
    // Clock, watchdog and verdict
    always #4 clk = ~clk;

    // A hung handshake must still end in the verdict
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_fail++;
            $display("mismatch at %0t: run did not finish", $time);
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ============================================================
    // Helpers
    task automatic chk_word(input logic [39:0] got, exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, exp, input string what);
        chk_word({39'h0, got}, {39'h0, exp}, what);
    endtask

    // Drive just after an edge, look in the low phase: what is seen
    // then is the outcome of the previous call
    task automatic cmd(input logic [2:0] st, en, input logic [3:0] wr,
                       input logic [17:0] a, d);
        @(posedge clk);
        {proc_burst_start_n, ctrl_burst_start_n, burst_advance_n} <= st;
        {chip_enable_primary_n, chip_enable_depth_hi,
         chip_enable_depth_lo_n} <= en;
        {global_write_n, write_strobe_n, byte_write_lane_hi_n,
         byte_write_lane_lo_n} <= wr;
        addr_in <= a;
        data_in <= d;
        output_enable_n <= oe_sel;
        burst_order_select <= order_sel;
        @(negedge clk);
    endtask

    function automatic logic [17:0] rdv(input logic [17:0] a);
        return a ^ 18'h2_aaaa;
    endfunction

    function automatic logic [17:0] nth(input logic [17:0] a, input int i,
                                        input logic il);
        logic [1:0] n;
        n = il ? a[1:0] ^ i[1:0] : a[1:0] + i[1:0];
        return {a[17:2], n};
    endfunction

    // Single-beat read from a deselected start
    task automatic rd1(input logic [17:0] a, exp);
        cmd(CS, PRI_OFF, NOWR, a, 18'h0_0000);
        cmd(PS, ON, NOWR, a, 18'h0_0000);
        cmd(HOLD, ON, NOWR, a, 18'h0_0000);
        cmd(HOLD, ON, NOWR, a, 18'h0_0000);
        chk_word(data_out, exp, "read back");
    endtask

    // ============================================================
    // Scenarios
    task automatic t_bursts;
        logic [17:0] a;
        oe_sel = 1'b0;
        for (int o = 0; o < 2; o++) begin
            for (int s = 0; s < 4; s++) begin
                order_sel = o[0];
                a = {16'h91b3, s[1:0]};
                cmd(CS, PRI_OFF, NOWR, a, 18'h0_0000);
                cmd(PS, ON, GW, a, 18'h0_0000);
                for (int i = 0; i < 5; i++) begin
                    cmd(BURST_ADVANCE_N, ON, NOWR, a, 18'h0_0000);
                    chk_word(mem_rd_addr, nth(a, i, o[0]), "address");
                    chk_flag(data_oe_n, i == 0, "drive");
                    if (i > 0)
                        chk_word(data_out, rdv(nth(a, i - 1, o[0])), "data");
                end
            end
        end
        $display("test bursts done");
    endtask

    task automatic t_suspend;
        logic [17:0] a;
        a = 18'h0_0402;
        oe_sel = 1'b1;
        order_sel = 1'b0;
        cmd(CS, PRI_OFF, NOWR, a, 18'h0_0000);
        cmd(PS, ON, NOWR, a, 18'h0_0000);
        cmd(HOLD, ON, NOWR, a, 18'h0_0000);
        cmd(HOLD, ON, NOWR, a, 18'h0_0000);
        chk_word(mem_rd_addr, a, "suspended address");
        chk_flag(data_oe_n, 1'b1, "drive off");
        #1 output_enable_n = 1'b0;
        #1 chk_flag(data_oe_n, 1'b0, "drive between edges");
        oe_sel = 1'b0;
        cmd(BURST_ADVANCE_N, ON, NOWR, a, 18'h0_0000);
        chk_word(data_out, rdv(a), "suspended data");
        cmd(HOLD, ON, NOWR, a, 18'h0_0000);
        chk_word(mem_rd_addr, a + 18'h0_0001, "advanced");
        $display("test suspend done");
    endtask

    task automatic t_writes;
        logic [17:0] a, b, c;
        a = 18'h0_1230;
        b = 18'h0_2344;
        c = 18'h0_3458;
        oe_sel = 1'b1;
        cmd(CS, ON, GW, a, 18'h3_c0f1);
        cmd(BURST_ADVANCE_N, ON, LLO, a, 18'h1_5a5a);
        chk_word(mem_wr, {a, 2'h3, 18'h3_c0f1}, "global");
        cmd(HOLD, ON, LHI, a, 18'h2_6b6b);
        chk_word(mem_wr, {a + 18'h1, 2'h1, 18'h1_5a5a}, "next");
        cmd(BURST_ADVANCE_N, ON, NOLANE, a, 18'h0_7777);
        chk_word(mem_wr, {a + 18'h1, 2'h2, 18'h2_6b6b}, "same");
        cmd(CS, ON, BOTH, b, 18'h0_9c3e);
        chk_flag(mem_wr_valid, 1'b0, "no lane");
        cmd(CS, ON, SWOFF, c, 18'h0_0000);
        chk_word(mem_wr, {b, 2'h3, 18'h0_9c3e}, "strobe");
        cmd(HOLD, ON, NOWR, c, 18'h0_0000);
        chk_flag(mem_rd, 1'b1, "read decode");
        chk_word(mem_rd_addr, c, "read address");
        for (int k = 0; k < 20 && mem_wr_valid !== 1'b0; k++)
            cmd(HOLD, ON, NOWR, c, 18'h0_0000);
        oe_sel = 1'b0;
        rd1(a, 18'h3_c0f1);
        rd1(a + 18'h1, {9'h135, 9'h05a});
        rd1(a + 18'h2, rdv(a + 18'h2));
        rd1(b, 18'h0_9c3e);
        $display("test writes done");
    endtask

    task automatic t_deselect;
        logic [2:0] st [5] = '{PS, PS, CS, CS, CS};
        logic [2:0] en [5] = '{HI_OFF, LO_OFF, PRI_OFF, HI_OFF, LO_OFF};
        logic [17:0] a;
        a = 18'h1_0005;
        cmd(CS, PRI_OFF, NOWR, a, 18'h0_0000);
        cmd(PS, ON, NOWR, a, 18'h0_0000);
        cmd(PSADV, PRI_OFF, NOWR, 18'h0_0aa8, 18'h0_0000);
        cmd(PS, PRI_OFF, NOWR, 18'h0_0bb4, 18'h0_0000);
        chk_word(mem_rd_addr, a + 18'h1, "start blocked");
        // Deselect first so the next processor start begins cleanly
        cmd(CS, PRI_OFF, NOWR, a, 18'h0_0000);
        chk_word(mem_rd_addr, a + 18'h1, "held");
        for (int k = 0; k < 5; k++) begin
            cmd(PS, ON, NOWR, a, 18'h0_0000);
            cmd(st[k], en[k], NOWR, a, 18'h0_0000);
            cmd(HOLD, ON, NOWR, a, 18'h0_0000);
            chk_flag(mem_rd, 1'b0, "deselect");
        end
        $display("test deselect done");
    endtask

    task automatic t_fifo;
        logic [17:0] a;
        oe_sel = 1'b1;
        @(posedge clk);
        stall <= 1'b1;
        for (int k = 0; k < 9; k++) begin
            a = 18'h0_4000 + 18'(k);
            cmd(CS, ON, GW, a, 18'h1_0000 + 18'(k));
        end
        chk_flag(wr_ready, 1'b0, "full");
        cmd(HOLD, ON, NOWR, a, 18'h0_0000);
        chk_flag(wr_overflow, 1'b1, "lost write");
        @(posedge clk);
        stall <= 1'b0;
        for (int k = 0; k < 20 && mem_wr_valid !== 1'b0; k++)
            cmd(HOLD, ON, NOWR, a, 18'h0_0000);
        chk_flag(wr_ready, 1'b1, "drained");
        oe_sel = 1'b0;
        rd1(18'h0_4007, 18'h1_0007);
        rd1(18'h0_4008, rdv(18'h0_4008));
        chk_flag(wr_overflow, 1'b1, "sticky");
        $display("test fifo done");
    endtask

    // ============================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        chk_flag(data_oe_n, 1'b1, "reset drive");
        chk_flag(mem_rd, 1'b0, "reset read");
        chk_flag(mem_wr_valid, 1'b0, "reset valid");
        chk_flag(wr_ready, 1'b1, "reset ready");
        chk_flag(wr_overflow, 1'b0, "reset overflow");
        chk_word(data_out, 40'h0, "reset data");
        $display("test reset done");
        t_bursts();
        t_suspend();
        t_writes();
        t_deselect();
        t_fifo();
        report_and_stop();
    end
endmodule
`default_nettype wire
